// *** include/input_decoder_defines.vh ***
// Offsets, field positions, reset values and function codes of the input decoder
`ifndef INPUT_DECODER_DEFINES_VH
`define INPUT_DECODER_DEFINES_VH
// Register byte addresses
`define OFS_INPUT_CFG0   8'h00
`define OFS_CONTROL      8'h20
`define OFS_STATUS       8'h24
`define OFS_IRQ_STATUS   8'h28
`define OFS_IRQ_CLEAR    8'h2c
`define OFS_IRQ_ENABLE   8'h30
// Input config fields
`define CFG_CODE_MSB     5
`define CFG_NC_BIT       8
`define CODE_NONE        6'h3f
// Control fields
`define CTL_RUN_SRC_LSB  0
`define CTL_LOCK_LSB     2
`define CTL_APAIR_LSB    4
`define CTL_ACK_LSB      6
`define CONTROL_RESET    8'h00
// Function codes
`define FN_FWD           6'h00
`define FN_REV           6'h01
`define FN_PRESET1       6'h02
`define FN_JOG           6'h06
`define FN_DCBRAKE       6'h07
`define FN_SET2          6'h08
`define FN_RAMP2         6'h09
`define FN_COAST         6'h0b
`define FN_EXTFAULT      6'h0c
`define FN_STARTLOCK     6'h0d
`define FN_WRLOCK        6'h0f
`define FN_ASWAP         6'h10
`define FN_FAULTACK      6'h12
// Mode values
`define RUN_SRC_TERM     2'h1
`define LOCK_ALL         2'h0
`define LOCK_FREQ        2'h1
`define APAIR_VI         2'h0
`define ACK_RISE         2'h0
`define ACK_FALL         2'h1
// Fault codes
`define FAULT_NONE       8'h00
`define FAULT_THERMAL    8'h0c
`define FAULT_STARTLOCK  8'h0d
// Parameter write classes
`define PCLASS_LOCKSCOPE 2'h0
`define PCLASS_FREQ      2'h1
// Event bits
`define EV_THERMAL       0
`define EV_STARTLOCK     1
`define EV_ACK           2
`define EV_SETCHG        3
`define EV_COUNT         4
// AXI responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// *** hdl/input_function_decoder.v ***
// Programmable digital input function decoder with AXI4-Lite configuration
// Function
// [RULE1] Terminal run source: forward and reverse both active gives stop.
// [RULE2] Codes 02..05 form a four-bit preset frequency index.
// [RULE3] Code 07 engages DC brake; also automatic below ramp-down threshold.
// [RULE4] Code 08 selects second parameter set, only at standstill without run.
// [RULE5] Set change is skipped when issued together with a run command; code holds it and applies it once the run command drops at standstill.
// [RULE6] Code 09 selects second ramp times while active.
// [RULE7] Code 11 disables power stage while active, motor coasts.
// [RULE8] Code 12 activation latches thermal trip until fault acknowledge.
// [RULE9] After acknowledge, running resumes at once if run command present.
// [RULE10] Code 13 with run at power-up latches start lock trip; cleared by ack or removal.
// [RULE11] Write lock with scope 00: only lock scope writable.
// [RULE12] Write lock with scope 01: lock scope and frequency parameters writable.
// [RULE13] Code 16, pair mode 00: voltage input when off, current when on.
// [RULE14] No swap input assigned: setpoint is voltage plus current input.
// [RULE15] Code 18 acknowledges fault; ack mode 00 disables stage while held; code does so only while a run command is present.
// [RULE16] A function code may be assigned to one input only; duplicates refused.
// [RULE17] Per-input polarity, normally open by reset default.
// [RULE18] Acknowledge refuses normally closed; ack mode 01 acts on falling edge.
// [RULE19] Inputs synchronised, polarity adjusted, routed by per-input code.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "input_decoder_defines.vh"
module input_function_decoder #(
  parameter NUM_IN = 7,
  parameter AW     = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [NUM_IN-1:0] term_in,
  input  wire              at_standstill,
  input  wire              below_brake_freq,
  input  wire [AW-1:0]     analog_in_voltage,
  input  wire [AW-1:0]     analog_in_current,
  input  wire              param_wr_req,
  input  wire [1:0]        param_wr_class,
  output wire              param_wr_accept,
  output reg               run_forward,
  output reg               run_reverse,
  output reg  [3:0]        preset_index,
  output reg               jog_active,
  output reg               dc_brake,
  output reg               param_set2,
  output reg               ramp2_select,
  output reg               stage_disable,
  output reg               fault_relay,
  output reg  [7:0]        fault_code,
  output reg  [AW:0]       setpoint,
  output wire              irq
);

  // Configuration state
  reg  [5:0]        code_q [0:NUM_IN-1];
  reg  [NUM_IN-1:0] nc_q;
  reg  [7:0]        control_q;
  reg  [`EV_COUNT-1:0] irq_status_q;
  reg  [`EV_COUNT-1:0] irq_enable_q;
  wire [1:0] run_src    = control_q[`CTL_RUN_SRC_LSB+1:`CTL_RUN_SRC_LSB];
  wire [1:0] lock_scope = control_q[`CTL_LOCK_LSB+1:`CTL_LOCK_LSB];
  wire [1:0] apair_mode = control_q[`CTL_APAIR_LSB+1:`CTL_APAIR_LSB];
  wire [1:0] ack_mode   = control_q[`CTL_ACK_LSB+1:`CTL_ACK_LSB];

  // Per-input synchroniser, polarity and routing
  reg  [NUM_IN-1:0] sync1_q;
  reg  [NUM_IN-1:0] sync2_q;
  wire [63:0]       fn_word [0:NUM_IN-1];
  wire [63:0]       asg_word [0:NUM_IN-1];
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi = gi + 1) begin : g_in
      // Second stage alone reads the first
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= term_in[gi];
          sync2_q[gi] <= sync1_q[gi]; // RULE19
        end
      end
      // Level after polarity, steered to its function
      assign fn_word[gi]  = ((sync2_q[gi] ^ nc_q[gi]) && code_q[gi] != `CODE_NONE) ?
                            (64'h1 << code_q[gi]) : 64'h0; // RULE17 RULE19
      assign asg_word[gi] = (code_q[gi] != `CODE_NONE) ? (64'h1 << code_q[gi]) : 64'h0;
    end
  endgenerate

  // Merge per-input contributions
  reg [63:0] fn_act;
  reg [63:0] fn_asg;
  integer k;
  always @* begin
    fn_act = 64'h0;
    fn_asg = 64'h0;
    for (k = 0; k < NUM_IN; k = k + 1) begin
      fn_act = fn_act | fn_word[k];
      fn_asg = fn_asg | asg_word[k];
    end
  end

  wire fwd_in   = fn_act[`FN_FWD];
  wire rev_in   = fn_act[`FN_REV];
  wire term_src = (run_src == `RUN_SRC_TERM);
  wire run_cmd  = term_src && (fwd_in || rev_in);
  wire wr_lock  = fn_act[`FN_WRLOCK];
  wire ack_in   = fn_act[`FN_FAULTACK];

  // Fault state
  reg        fault_q;
  reg  [7:0] fcode_q;
  reg        ext_prev_q;
  reg        ack_prev_q;
  reg        pwr_armed_q;
  wire       ext_rise  = fn_act[`FN_EXTFAULT] && !ext_prev_q;
  wire       ack_edge  = (ack_mode == `ACK_FALL) ? (ack_prev_q && !ack_in) : (ack_in && !ack_prev_q); // RULE18
  // Settings load after reset, so the power-up check waits until the lock takes effect
  wire       pwr_check = pwr_armed_q && fn_asg[`FN_STARTLOCK] && term_src;
  wire       usp_trip  = pwr_check && fn_asg[`FN_STARTLOCK] && run_cmd;
  wire       usp_drop  = fault_q && fcode_q == `FAULT_STARTLOCK && !run_cmd;

  // Fault latch: a new trip wins over an acknowledge in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      fault_q    <= 1'b0;
      fcode_q    <= `FAULT_NONE;
      ext_prev_q <= 1'b0;
      ack_prev_q <= 1'b0;
      pwr_armed_q <= 1'b1;
    end else begin
      ext_prev_q <= fn_act[`FN_EXTFAULT];
      ack_prev_q <= ack_in;
      if (pwr_check)
        pwr_armed_q <= 1'b0; // RULE10
      if (ext_rise) begin
        fault_q <= 1'b1; // RULE8
        fcode_q <= `FAULT_THERMAL;
      end else if (usp_trip) begin
        fault_q <= 1'b1; // RULE10
        fcode_q <= `FAULT_STARTLOCK;
      end else if ((fault_q && ack_edge) || usp_drop) begin
        fault_q <= 1'b0; // RULE15 RULE10
        fcode_q <= `FAULT_NONE;
      end
    end
  end

  // Second parameter set, switched only while stopped
  reg set2_q;
  wire set_change = at_standstill && !run_cmd && (fn_act[`FN_SET2] != set2_q); // RULE4 RULE5
  always @(posedge aclk) begin
    if (!aresetn) begin
      set2_q <= 1'b0;
    end else begin
      if (set_change)
        set2_q <= fn_act[`FN_SET2];
    end
  end

  // Drive commands, registered; run follows fault release with no new edge
  wire running = run_cmd && !fault_q;
  wire ack_coast = ack_in && (ack_mode == `ACK_RISE || ack_mode == `ACK_FALL);
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_forward   <= 1'b0;
      run_reverse   <= 1'b0;
      preset_index  <= 4'h0;
      jog_active    <= 1'b0;
      dc_brake      <= 1'b0;
      param_set2    <= 1'b0;
      ramp2_select  <= 1'b0;
      stage_disable <= 1'b0;
      fault_relay   <= 1'b0;
      fault_code    <= `FAULT_NONE;
      setpoint      <= {(AW+1){1'b0}};
    end else begin
      run_forward   <= running && fwd_in && !rev_in; // RULE1 RULE9
      run_reverse   <= running && rev_in && !fwd_in; // RULE1 RULE9
      preset_index  <= fn_act[`FN_PRESET1+3:`FN_PRESET1]; // RULE2
      jog_active    <= fn_act[`FN_JOG];
      dc_brake      <= fn_act[`FN_DCBRAKE] || below_brake_freq; // RULE3
      param_set2    <= set2_q;
      ramp2_select  <= fn_act[`FN_RAMP2]; // RULE6
      stage_disable <= fn_act[`FN_COAST] || (ack_coast && run_cmd); // RULE7 RULE15
      fault_relay   <= fault_q;
      fault_code    <= fcode_q;
      if (!fn_asg[`FN_ASWAP])
        setpoint <= {1'b0, analog_in_voltage} + {1'b0, analog_in_current}; // RULE14
      else if (fn_act[`FN_ASWAP])
        setpoint <= {1'b0, analog_in_current}; // RULE13
      else
        setpoint <= {1'b0, analog_in_voltage}; // RULE13
    end
  end

  // Parameter write filter
  assign param_wr_accept = param_wr_req && (!wr_lock ||
                           param_wr_class == `PCLASS_LOCKSCOPE || // RULE11
                           (lock_scope == `LOCK_FREQ && param_wr_class == `PCLASS_FREQ)); // RULE12

  // Interrupt events
  wire [`EV_COUNT-1:0] events = {set_change, fault_q && ack_edge, usp_trip, ext_rise};
  assign irq = |(irq_status_q & irq_enable_q);

  // Bus write channel: address and data caught in either order
  reg        aw_full_q;
  reg        w_full_q;
  reg  [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg  [3:0] w_strb_q;
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
  wire       do_write  = aw_full_q && w_full_q && !s_axi_bvalid;
  wire [7:0] wa        = aw_addr_q;
  wire       wa_cfg    = (wa[7:2] < NUM_IN);
  wire [2:0] wa_idx    = wa[4:2];
  wire [5:0] new_code  = w_data_q[`CFG_CODE_MSB:0];
  wire       new_nc    = w_data_q[`CFG_NC_BIT];

  // Refuse a code already owned by another input, or acknowledge as closer
  reg cfg_bad;
  integer j;
  always @* begin
    cfg_bad = (new_code == `FN_FAULTACK) && new_nc; // RULE18
    for (j = 0; j < NUM_IN; j = j + 1) begin
      if (j != wa_idx && new_code != `CODE_NONE && code_q[j] == new_code)
        cfg_bad = 1'b1; // RULE16
    end
  end

  // Register writes and interrupt status
  integer m;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      control_q    <= `CONTROL_RESET;
      irq_enable_q <= {`EV_COUNT{1'b0}};
      irq_status_q <= {`EV_COUNT{1'b0}};
      nc_q         <= {NUM_IN{1'b0}}; // RULE17
      for (m = 0; m < NUM_IN; m = m + 1)
        code_q[m] <= `CODE_NONE;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Clear first, set after: a same-cycle event survives
      if (do_write && wa == `OFS_IRQ_CLEAR && w_strb_q[0])
        irq_status_q <= (irq_status_q & ~w_data_q[`EV_COUNT-1:0]) | events;
      else
        irq_status_q <= irq_status_q | events;
      if (do_write) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        if (wa[1:0] != 2'h0) begin
          s_axi_bresp <= `RESP_SLVERR;
        end else if (wa_cfg) begin
          if (cfg_bad)
            s_axi_bresp <= `RESP_SLVERR;
          else if (w_strb_q[0] && w_strb_q[1]) begin
            code_q[wa_idx] <= new_code;
            nc_q[wa_idx]   <= new_nc;
          end
        end else if (wa == `OFS_CONTROL) begin
          if (w_strb_q[0])
            control_q <= w_data_q[7:0];
        end else if (wa == `OFS_IRQ_ENABLE) begin
          if (w_strb_q[0])
            irq_enable_q <= w_data_q[`EV_COUNT-1:0];
        end else if (wa != `OFS_IRQ_CLEAR && wa != `OFS_STATUS && wa != `OFS_IRQ_STATUS) begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
    end
  end

  // Read channel: one word, answered the cycle after the address
  wire [7:0] ra = s_axi_araddr;
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RESP_OKAY;
      s_axi_rdata  <= 32'h0;
      if (ra[1:0] != 2'h0)
        s_axi_rresp <= `RESP_SLVERR;
      else if (ra[7:2] < NUM_IN)
        s_axi_rdata <= {23'h0, nc_q[ra[4:2]], 2'h0, code_q[ra[4:2]]};
      else if (ra == `OFS_CONTROL)
        s_axi_rdata <= {24'h0, control_q};
      else if (ra == `OFS_STATUS)
        s_axi_rdata <= {15'h0, set2_q, fcode_q, fault_q, sync2_q ^ nc_q}; // status word, inputs low
      else if (ra == `OFS_IRQ_STATUS)
        s_axi_rdata <= {{(32-`EV_COUNT){1'b0}}, irq_status_q};
      else if (ra == `OFS_IRQ_ENABLE)
        s_axi_rdata <= {{(32-`EV_COUNT){1'b0}}, irq_enable_q};
      else if (ra != `OFS_IRQ_CLEAR)
        s_axi_rresp <= `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // input_function_decoder
`default_nettype wire

// *** verification/decoder_checker_assertions.sv ***
// Port-level checker for the input function decoder
`timescale 1ns/10ps
`default_nettype none
`include "input_decoder_defines.vh"
module decoder_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       below_brake_freq,
  input wire logic       param_wr_req,
  input wire logic [1:0] param_wr_class,
  input wire logic       param_wr_accept,
  input wire logic       run_forward,
  input wire logic       run_reverse,
  input wire logic       dc_brake,
  input wire logic       fault_relay,
  input wire logic [7:0] fault_code
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Drive command relations
  property p_no_both_run;
    !(run_forward && run_reverse);
  endproperty
  a_no_both_run: assert property (p_no_both_run) else $error("both run outputs high");
  property p_fault_stops;
    fault_relay |-> !run_forward && !run_reverse;
  endproperty
  a_fault_stops: assert property (p_fault_stops) else $error("run output during fault");
  property p_code_relay;
    fault_relay == (fault_code != `FAULT_NONE);
  endproperty
  a_code_relay: assert property (p_code_relay) else $error("fault relay and code disagree");
  // Brake lags the threshold by the output register only
  property p_brake_auto;
    below_brake_freq [*5] |-> dc_brake;
  endproperty
  a_brake_auto: assert property (p_brake_auto) else $error("automatic brake missing");
  property p_reset_quiet;
    $rose(aresetn) |-> (fault_code == `FAULT_NONE) [*3];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("fault right after reset");

  // Parameter store gating
  property p_lock_scope;
    param_wr_req && param_wr_class == `PCLASS_LOCKSCOPE |-> param_wr_accept;
  endproperty
  a_lock_scope: assert property (p_lock_scope) else $error("lock scope write refused");
  property p_accept_req;
    param_wr_accept |-> param_wr_req;
  endproperty
  a_accept_req: assert property (p_accept_req) else $error("accept without request");

  // Responses stand until taken
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read response dropped");

  // Main scenarios
  c_fault: cover property ($rose(fault_relay));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_reject: cover property (param_wr_req && !param_wr_accept);
endmodule // decoder_checker

bind input_function_decoder decoder_checker u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rvalid, .s_axi_rready, .below_brake_freq, .param_wr_req, .param_wr_class, .param_wr_accept,
  .run_forward, .run_reverse, .dc_brake, .fault_relay, .fault_code);
`default_nettype wire

// *** verification/terminal_controller.sv ***
// Behavioural machine controller driving the terminal inputs
`timescale 1ns/10ps
`default_nettype none
module terminal_controller (
  input  wire logic       clk,
  input  wire logic [6:0] want,
  input  wire logic       slow,
  output wire logic [6:0] term_in
);
  logic [6:0] s1 = 7'h00;
  logic [6:0] s2 = 7'h00;
  logic [6:0] s3 = 7'h00;
  // Contact lag; slow mode adds a relay cycle
  always @(posedge clk) begin
    s1 <= want;
    s2 <= s1;
    s3 <= s2;
  end
  // Run contacts close a cycle late so a set change always leads
  assign term_in[6:2] = slow ? s2[6:2] : s1[6:2];
  assign term_in[1:0] = slow ? s3[1:0] : s2[1:0];
endmodule // terminal_controller
`default_nettype wire

// *** verification/digital_input_function_decoder_tb.sv ***
// Self-checking bench for the input function decoder
`timescale 1ns/10ps
`default_nettype none
`include "input_decoder_defines.vh"
module digital_input_function_decoder_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        at_standstill = 1'b1, below_brake_freq = 1'b0, param_wr_req = 1'b0;
  logic [1:0]  param_wr_class = 2'h0, cls;
  logic [11:0] analog_in_voltage = 12'h000, analog_in_current = 12'h000, v, c;
  logic [6:0]  want = 7'h00;
  logic [5:0]  fn [0:6] = '{`FN_FWD, `FN_REV, `FN_EXTFAULT, `FN_FAULTACK, `FN_ASWAP, `FN_SET2, `FN_WRLOCK};
  wire  [6:0]  term_in;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         param_wr_accept, run_forward, run_reverse, dc_brake, param_set2, stage_disable, fault_relay, irq;
  wire         jog_active, ramp2_select;
  wire  [3:0]  preset_index;
  wire  [7:0]  fault_code;
  wire  [12:0] setpoint;
  integer      failures = 0, total_checks = 0, seed = 59711, i, j, k;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  input_function_decoder uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .term_in,
    .at_standstill, .below_brake_freq, .analog_in_voltage, .analog_in_current, .param_wr_req, .param_wr_class,
    .param_wr_accept, .run_forward, .run_reverse, .preset_index, .jog_active, .dc_brake, .param_set2,
    .ramp2_select, .stage_disable, .fault_relay, .fault_code, .setpoint, .irq);
  terminal_controller ctl (.clk(aclk), .want, .slow, .term_in);

  task give_verdict;
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_resp(input [1:0] got, input [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  // Terminal pipeline plus partner lag, with margin
  task settle;
    repeat (9) @(posedge aclk);
  endtask
  task draw;
    k = $random(seed);
    v = k[11:0];
    c = k[23:12];
    cls = k[25:24];
    analog_in_voltage <= v;
    analog_in_current <= c;
  endtask
  // Bus master: hold each channel until its own handshake
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle limit here: only the watchdog ends a wait
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_resp(s_axi_bresp, er);
  endtask
  task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk_resp(s_axi_rresp, er);
    if (er == `RESP_OKAY) chk(s_axi_rdata, exp);
  endtask
  function [12:0] exp_sp(input sw, input on, input [11:0] vv, input [11:0] cc);
    exp_sp = !sw ? {1'b0, vv} + {1'b0, cc} : (on ? {1'b0, cc} : {1'b0, vv});
  endfunction
  function exp_acc(input lk, input [1:0] sc, input [1:0] cl);
    exp_acc = !lk || cl == `PCLASS_LOCKSCOPE || (sc == `LOCK_FREQ && cl == `PCLASS_FREQ);
  endfunction

  // Main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_INPUT_CFG0, {26'h0, `CODE_NONE}, `RESP_OKAY);
    rd(8'h80, 32'h0, `RESP_SLVERR);
    draw;
    settle;
    chk(setpoint, exp_sp(1'b0, 1'b0, v, c));
    wr(8'h0c, {23'h0, 1'b1, 2'h0, `FN_FAULTACK}, `RESP_SLVERR);
    for (i = 0; i < 7; i++) wr(8'(4 * i), {26'h0, fn[i]}, `RESP_OKAY);
    wr(8'h18, {26'h0, `FN_FWD}, `RESP_SLVERR);
    rd(8'h18, {26'h0, `FN_WRLOCK}, `RESP_OKAY);
    wr(`OFS_CONTROL, {30'h0, `RUN_SRC_TERM}, `RESP_OKAY);
    at_standstill <= 1'b0;
    want <= 7'h20;
    settle;
    chk(param_set2, 1'b0);
    at_standstill <= 1'b1;
    settle;
    chk(param_set2, 1'b1);
    want <= 7'h21;
    settle;
    want <= 7'h01;
    settle;
    chk(param_set2, 1'b1);
    want <= 7'h00;
    settle;
    chk(param_set2, 1'b0);
    for (i = 1; i < 4; i++) begin
      want <= 7'(i);
      settle;
      chk(run_forward, i == 1);
      chk(run_reverse, i == 2);
    end
    // Thermal trip, masking and acknowledge
    wr(`OFS_IRQ_CLEAR, 32'hf, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE, 32'h1 << `EV_THERMAL, `RESP_OKAY);
    want <= 7'h05;
    settle;
    chk(fault_code, `FAULT_THERMAL);
    chk(irq, 1'b1);
    want <= 7'h01;
    settle;
    chk(fault_relay, 1'b1);
    rd(`OFS_IRQ_STATUS, 32'h1 << `EV_THERMAL, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE, 32'h0, `RESP_OKAY);
    chk(irq, 1'b0);
    want <= 7'h09;
    settle;
    chk(stage_disable, 1'b1);
    chk(fault_relay, 1'b0);
    want <= 7'h01;
    settle;
    chk(run_forward, 1'b1);
    wr(`OFS_IRQ_CLEAR, 32'hf, `RESP_OKAY);
    wr(`OFS_IRQ_ENABLE, 32'h1, `RESP_OKAY);
    chk(irq, 1'b0);
    // Falling-edge acknowledge with a sluggish controller
    slow <= 1'b1;
    wr(`OFS_CONTROL, {24'h0, `ACK_FALL, 4'h0, `RUN_SRC_TERM}, `RESP_OKAY);
    want <= 7'h05;
    settle;
    want <= 7'h09;
    settle;
    chk(fault_relay, 1'b1);
    want <= 7'h01;
    settle;
    chk(fault_relay, 1'b0);
    for (i = 0; i < 2; i++) begin
      draw;
      want <= {2'h0, i[0], 4'h0};
      settle;
      chk(setpoint, exp_sp(1'b1, i[0], v, c));
    end
    // Write lock scopes against random parameter classes
    for (j = 0; j < 2; j++) begin
      wr(`OFS_CONTROL, {28'h0, 2'(j), `RUN_SRC_TERM}, `RESP_OKAY);
      want <= 7'h40;
      settle;
      for (i = 0; i < 8; i++) begin
        draw;
        param_wr_req <= 1'b1;
        param_wr_class <= cls;
        @(posedge aclk);
        chk(param_wr_accept, exp_acc(1'b1, 2'(j), cls));
      end
    end
    // Preset index bits and jog, jog contact wired normally closed
    want <= 7'h00;
    for (i = 2; i < 6; i++) wr(8'(4 * i), {26'h0, 6'(`FN_PRESET1 + i - 2)}, `RESP_OKAY);
    wr(8'h18, {23'h0, 1'b1, 2'h0, `FN_JOG}, `RESP_OKAY);
    for (i = 0; i < 4; i++) begin
      draw;
      want <= {k[6:2], 2'h0};
      settle;
      chk(preset_index, k[5:2]);
      chk(jog_active, !k[6]);
    end
    // Start lock becomes effective while the run contact is closed
    want <= 7'h01;
    wr(8'h08, {26'h0, `FN_DCBRAKE}, `RESP_OKAY);
    wr(8'h0c, {26'h0, `FN_RAMP2}, `RESP_OKAY);
    wr(8'h10, {26'h0, `FN_COAST}, `RESP_OKAY);
    wr(8'h14, {26'h0, `FN_STARTLOCK}, `RESP_OKAY);
    settle;
    chk(fault_code, `FAULT_STARTLOCK);
    want <= 7'h00;
    settle;
    chk(fault_relay, 1'b0);
    // Brake, second ramp and coast follow their inputs
    for (i = 0; i < 4; i++) begin
      draw;
      want <= {2'h0, k[4:2], 2'h0};
      settle;
      chk(dc_brake, k[2]);
      chk(ramp2_select, k[3]);
      chk(stage_disable, k[4]);
    end
    want <= 7'h00;
    below_brake_freq <= 1'b1;
    settle;
    chk(param_wr_accept, exp_acc(1'b0, 2'h0, cls));
    chk(dc_brake, 1'b1);
    give_verdict;
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
endmodule // digital_input_function_decoder_tb
`default_nettype wire
